// ===== logic/msc_pkg.sv
// shared constants for the multi-device sync counter block
package msc_pkg;

  //==========================================================================
  // widths
  localparam int CNT_W = 14;
  localparam int REG_W = 8;
  localparam int RATE_W = 3;
  localparam int CRC_W = 16;
  localparam int FRAME_BITS = 32;
  localparam int BITCNT_W = 6;
  localparam int FLAG_PAD_W = 5;

  //==========================================================================
  // command and response word fields
  localparam int CMD_RW_BIT = 31;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CMD_DATA_LSB = 8;
  localparam int RESP_DATA_LSB = 16;

  //==========================================================================
  // register map
  localparam logic [REG_W-1:0] ADDR_FILTER_CFG = 8'h10;
  localparam logic [REG_W-1:0] ADDR_SYNC_CTRL = 8'h11;
  localparam logic [REG_W-1:0] ADDR_CNT_HIGH = 8'h12;
  localparam logic [REG_W-1:0] ADDR_CNT_LOW = 8'h13;
  localparam int SYNC_ALIGN_BIT = 0;
  localparam int SYNC_CAPTURE_BIT = 1;
  localparam int SYNC_RELEASE_BIT = 2;
  localparam logic [RATE_W-1:0] RATE_RESET = 3'h0;

  //==========================================================================
  // rate codes and period reload values
  localparam logic [RATE_W-1:0] RATE_32K = 3'h0;
  localparam logic [RATE_W-1:0] RATE_C1 = 3'h1;
  localparam logic [RATE_W-1:0] RATE_C2 = 3'h2;
  localparam logic [RATE_W-1:0] RATE_8K = 3'h3;
  localparam logic [RATE_W-1:0] RATE_C4 = 3'h4;
  localparam logic [RATE_W-1:0] RATE_4K = 3'h5;
  localparam logic [RATE_W-1:0] RATE_2K = 3'h6;
  localparam logic [CNT_W-1:0] RELOAD_32K = 14'h01FF;
  localparam logic [CNT_W-1:0] RELOAD_8K = 14'h07FF;
  localparam logic [CNT_W-1:0] RELOAD_4K = 14'h0FFF;
  localparam logic [CNT_W-1:0] RELOAD_2K = 14'h1FFF;
  localparam logic [CNT_W-1:0] RELOAD_1K = 14'h3FFF;
  localparam logic [CNT_W-1:0] RELOAD_C1_DEF = 14'h03FF;
  localparam logic [CNT_W-1:0] RELOAD_C2_DEF = 14'h05FF;
  localparam logic [CNT_W-1:0] RELOAD_C4_DEF = 14'h0BFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;

  //==========================================================================
  // response check and settling
  localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
  localparam logic [CRC_W-1:0] CRC_INIT = 16'hFFFF;
  localparam logic [1:0] SETTLE_PERIODS = 2'h3;
  localparam logic [1:0] SETTLE_ONE = 2'h1;
  localparam logic [BITCNT_W-1:0] BITCNT_ONE = 6'h01;

endpackage

// ===== logic/msc_crc16.sv
// response check word generator, msb first
module msc_crc16
  import msc_pkg::*;
(
  input logic [CRC_W-1:0] data_i,
  output logic [CRC_W-1:0] crc_o
);

  //==========================================================================
  // one bit step
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] crc,
                                               input logic din);
    logic fb;
    fb = crc[CRC_W-1] ^ din;
    crc_step = {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
  endfunction

  //==========================================================================
  // whole word, preset register
  always_comb begin
    crc_o = CRC_INIT;
    for (int i = CRC_W - 1; i >= 0; i--) begin
      crc_o = crc_step(crc_o, data_i[i]);
    end
  end

endmodule

// ===== logic/msc_period_counter.sv
// output period down counter on the crystal clock
module msc_period_counter
  import msc_pkg::*;
#(
  parameter logic [CNT_W-1:0] RELOAD_C1 = RELOAD_C1_DEF,
  parameter logic [CNT_W-1:0] RELOAD_C2 = RELOAD_C2_DEF,
  parameter logic [CNT_W-1:0] RELOAD_C4 = RELOAD_C4_DEF
)(
  input logic ref_clk_i,
  input logic resetn_i,
  input logic ce_i,
  input logic restart_i,
  input logic [RATE_W-1:0] rate_i,
  output logic [CNT_W-1:0] count_o,
  output logic ready_o
);

  //==========================================================================
  // reload value per rate code
  function automatic logic [CNT_W-1:0] reload_of(input logic [RATE_W-1:0] rate);
    case (rate)
      RATE_32K: reload_of = RELOAD_32K;
      RATE_C1: reload_of = RELOAD_C1;
      RATE_C2: reload_of = RELOAD_C2;
      RATE_8K: reload_of = RELOAD_8K;
      RATE_C4: reload_of = RELOAD_C4;
      RATE_4K: reload_of = RELOAD_4K;
      RATE_2K: reload_of = RELOAD_2K;
      default: reload_of = RELOAD_1K;
    endcase
  endfunction

  //==========================================================================
  // counter
  wire period_end = (count_o == '0);
  wire reload_now = restart_i | period_end;
  wire [CNT_W-1:0] count_d = reload_now ? reload_of(rate_i) : count_o - CNT_ONE; // [RULE6]

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= RELOAD_32K;
      ready_o <= 1'b0;
    end else if (ce_i) begin
      count_o <= count_d; // [RULE5]
      ready_o <= reload_now;
    end
  end

  //==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_reload_value: assert property (ce_i && reload_now |=> // [RULE6]
    count_o == reload_of($past(rate_i)) && ready_o)
    else $error("period counter reloaded with wrong value");

  a_count_down: assert property (ce_i && !reload_now |=> // [RULE5]
    count_o == $past(count_o) - CNT_ONE && !ready_o)
    else $error("period counter did not step down by one");

endmodule

// ===== logic/msc_sync_top.sv
// multi-device sync counter: serial port, sync control, counter capture
//==========================================================================
// Functional notes
// [RULE1] each response word carries a 16-bit check, poly 0x1021, preset all ones
// [RULE2] host gives every device the same rate code and the same clock
// [RULE3] release bit set: data output floats for the whole next frame
// [RULE4] host sets release bit for shared output lines, clears it in a chain
// [RULE5] a 14-bit period counter runs on the crystal clock, tied to sample ready
// [RULE6] each period reloads by rate code: 511, 2047, 4095, 8191, 16383
// [RULE7] counter captured on first select fall after align or capture written
// [RULE8] align and capture bits clear themselves one cycle after acting
// [RULE9] captured count readable as high and low 8-bit registers
// [RULE10] host deems devices in step when captures differ by at most one
// [RULE11] host realigns: align set, all selects toggled, waits three periods
// [RULE12] the select toggle may be a clockless frame or a real command
// [RULE13] host realigns preferably only at power-up or after a reset
// [RULE14] host check: capture set, selects toggled, both counts read, compared
// [RULE15] realign while sampling may disturb up to three samples
// [RULE16] host avoids frequent realigns, only when counts differ by more than one
// [RULE17] one broadcast request latches all devices on the same select edge
// [RULE18] realign restarts the output period timing
// [RULE19] high register holds count bits 13..8 low, upper bits zero
// [RULE20] codes 001, 010, 100 use parameter reload values
module msc_sync_top
  import msc_pkg::*;
#(
  parameter logic [CNT_W-1:0] RELOAD_C1 = RELOAD_C1_DEF,
  parameter logic [CNT_W-1:0] RELOAD_C2 = RELOAD_C2_DEF,
  parameter logic [CNT_W-1:0] RELOAD_C4 = RELOAD_C4_DEF
)(
  input logic ref_clk_i,
  input logic resetn_i,
  input logic ce_i,
  input logic sclk_i,
  input logic cs_n_i,
  input logic mosi_i,
  output logic miso_o,
  output logic miso_oen_o,
  output logic sample_ready_o,
  output logic settling_o
);

  //==========================================================================
  // declarations
  logic [FRAME_BITS-1:0] shift_q;
  logic [BITCNT_W-1:0] bitcnt_q;
  logic miso_q;
  logic [FRAME_BITS-1:0] resp_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic full_s1_q;
  logic full_s2_q;
  logic full_seen_q;
  logic [RATE_W-1:0] rate_q;
  logic align_q;
  logic capture_q;
  logic rel_pend_q;
  logic rel_act_q;
  logic miso_oen_q;
  logic [CNT_W-1:0] cap_cnt_q;
  logic [REG_W-1:0] last_addr_q;
  logic last_wr_q;
  logic resp_load_q;
  logic [1:0] settle_q;
  logic settling_q;
  logic [CNT_W-1:0] count_w;
  logic [CRC_W-1:0] crc_w;

  //==========================================================================
  // link side: shift in on rising edge, shift out on falling edge
  wire link_rst_n = resetn_i & ~cs_n_i;
  wire past_resp = bitcnt_q[BITCNT_W-1];
  wire resp_bit = resp_q[~bitcnt_q[BITCNT_W-2:0]];
  wire miso_d = past_resp ? shift_q[FRAME_BITS-1] : resp_bit;

  always_ff @(posedge sclk_i or negedge resetn_i) begin
    if (!resetn_i)
      shift_q <= '0;
    else
      shift_q <= {shift_q[FRAME_BITS-2:0], mosi_i};
  end

  always_ff @(posedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n)
      bitcnt_q <= '0;
    else if (!past_resp)
      bitcnt_q <= bitcnt_q + BITCNT_ONE;
  end

  // first bit of every response is the fixed marker one
  always_ff @(negedge sclk_i or negedge link_rst_n) begin
    if (!link_rst_n)
      miso_q <= 1'b1;
    else
      miso_q <= miso_d;
  end

  assign miso_o = miso_q;

  //==========================================================================
  // crossing into the crystal domain
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      full_s1_q <= 1'b0;
      full_s2_q <= 1'b0;
    end else if (ce_i) begin
      cs_s1_q <= cs_n_i;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      full_s1_q <= past_resp;
      full_s2_q <= full_s1_q;
    end
  end

  // select edges act with or without any serial clock pulse
  wire cs_fall = cs_s3_q & ~cs_s2_q; // [RULE12]
  wire cs_rise = ~cs_s3_q & cs_s2_q;
  wire full_seen_d = cs_rise ? 1'b0 : (full_seen_q | (full_s2_q & ~cs_s2_q));
  wire cmd_ok = cs_rise & full_seen_q; // [RULE12]

  //==========================================================================
  // command decode; the shift word is still while select is high
  wire [FRAME_BITS-1:0] cmd_w = shift_q;
  wire cmd_rd = cmd_w[CMD_RW_BIT];
  wire [REG_W-1:0] cmd_addr = cmd_w[CMD_ADDR_LSB +: REG_W];
  wire [REG_W-1:0] cmd_data = cmd_w[CMD_DATA_LSB +: REG_W];
  wire wr_en = cmd_ok & ~cmd_rd;
  wire wr_filter = wr_en & (cmd_addr == ADDR_FILTER_CFG);
  wire wr_sync = wr_en & (cmd_addr == ADDR_SYNC_CTRL);

  //==========================================================================
  // sync control: capture, realign, output release
  wire req_any = align_q | capture_q;
  wire take = cs_fall & req_any; // [RULE7] [RULE17]
  wire restart = take & align_q; // [RULE18]
  wire align_d = wr_sync ? cmd_data[SYNC_ALIGN_BIT] : (align_q & ~take); // [RULE8]
  wire capture_d = wr_sync ? cmd_data[SYNC_CAPTURE_BIT] : (capture_q & ~take); // [RULE8]
  wire rel_pend_d = wr_sync ? cmd_data[SYNC_RELEASE_BIT] : (rel_pend_q & ~cs_fall);
  wire rel_act_d = cs_fall ? rel_pend_q : (rel_act_q & ~cs_rise); // [RULE3]
  wire oen_d = cs_s2_q | rel_act_d; // [RULE3]
  wire [CNT_W-1:0] cap_cnt_d = take ? count_w : cap_cnt_q; // [RULE7]

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      full_seen_q <= 1'b0;
      align_q <= 1'b0;
      capture_q <= 1'b0;
      rel_pend_q <= 1'b0;
      rel_act_q <= 1'b0;
      miso_oen_q <= 1'b1;
      cap_cnt_q <= '0;
    end else if (ce_i) begin
      full_seen_q <= full_seen_d;
      align_q <= align_d;
      capture_q <= capture_d;
      rel_pend_q <= rel_pend_d;
      rel_act_q <= rel_act_d;
      miso_oen_q <= oen_d;
      cap_cnt_q <= cap_cnt_d;
    end
  end

  assign miso_oen_o = miso_oen_q;

  //==========================================================================
  // rate select and period counter
  wire [RATE_W-1:0] rate_d = wr_filter ? cmd_data[RATE_W-1:0] : rate_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i)
      rate_q <= RATE_RESET;
    else if (ce_i)
      rate_q <= rate_d;
  end

  msc_period_counter #(
    .RELOAD_C1(RELOAD_C1), // [RULE20]
    .RELOAD_C2(RELOAD_C2),
    .RELOAD_C4(RELOAD_C4)
  ) u_period (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .restart_i(restart), // [RULE18]
    .rate_i(rate_q),
    .count_o(count_w),
    .ready_o(sample_ready_o)
  );

  //==========================================================================
  // settling window after a realign
  wire settle_dec = sample_ready_o & (settle_q != '0);
  wire [1:0] settle_d = restart ? SETTLE_PERIODS :
                        (settle_dec ? settle_q - SETTLE_ONE : settle_q); // [RULE15]

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_q <= '0;
      settling_q <= 1'b0;
    end else if (ce_i) begin
      settle_q <= settle_d;
      settling_q <= (settle_d != '0); // [RULE15]
    end
  end

  assign settling_o = settling_q;

  //==========================================================================
  // register read mux for the response
  wire hit_filter = (last_addr_q == ADDR_FILTER_CFG);
  wire hit_sync = (last_addr_q == ADDR_SYNC_CTRL);
  wire hit_hi = (last_addr_q == ADDR_CNT_HIGH);
  wire hit_lo = (last_addr_q == ADDR_CNT_LOW);
  wire [REG_W-1:0] rd_filter = {{(REG_W-RATE_W){1'b0}}, rate_q};
  wire [REG_W-1:0] rd_sync = {{FLAG_PAD_W{1'b0}}, rel_pend_q, capture_q, align_q};
  wire [REG_W-1:0] rd_cnt_hi = {{(2*REG_W-CNT_W){1'b0}}, cap_cnt_q[CNT_W-1:REG_W]}; // [RULE19]
  wire [REG_W-1:0] rd_cnt_lo = cap_cnt_q[REG_W-1:0]; // [RULE9]
  wire [REG_W-1:0] rdata = hit_filter ? rd_filter :
                           hit_sync ? rd_sync :
                           hit_hi ? rd_cnt_hi :
                           hit_lo ? rd_cnt_lo : '0;
  wire [REG_W-1:0] status = {1'b1, settling_q, last_wr_q, {FLAG_PAD_W{1'b0}}};

  msc_crc16 u_crc (
    .data_i({status, rdata}), // [RULE1]
    .crc_o(crc_w)
  );

  wire [FRAME_BITS-1:0] resp_d = {status, rdata, crc_w}; // [RULE1]

  //==========================================================================
  // response build one cycle after a command, so written values read back
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_addr_q <= '0;
      last_wr_q <= 1'b0;
      resp_load_q <= 1'b1;
      resp_q <= '0;
    end else if (ce_i) begin
      last_addr_q <= cmd_ok ? cmd_addr : last_addr_q;
      last_wr_q <= cmd_ok ? ~cmd_rd : last_wr_q;
      resp_load_q <= cmd_ok;
      resp_q <= resp_load_q ? resp_d : resp_q;
    end
  end

  //==========================================================================
  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_take;
    ce_i && cs_fall && req_any;
  endsequence

  sequence s_align_take;
    ce_i && cs_fall && align_q;
  endsequence

  sequence s_load_hi;
    ce_i && resp_load_q && hit_hi;
  endsequence

  sequence s_release_start;
    ce_i && cs_fall && rel_pend_q;
  endsequence

  sequence s_drive_start;
    ce_i && cs_fall && !rel_pend_q;
  endsequence

  sequence s_settle_last;
    ce_i && sample_ready_o && (settle_q == SETTLE_ONE) && !restart;
  endsequence

  a_capture_at_fall: assert property (s_take |=> cap_cnt_q == $past(count_w)) // [RULE7]
    else $error("count not captured on select fall");

  a_bits_self_clear: assert property (s_take |=> !align_q && !capture_q) // [RULE8]
    else $error("align or capture bit did not clear");

  a_align_restart: assert property (s_align_take |=> sample_ready_o) // [RULE18]
    else $error("realign did not restart the period");

  a_settle_window: assert property (s_align_take |=> settling_q ##1 settling_q) // [RULE15]
    else $error("settling flag not raised after realign");

  a_release_hiz: assert property (rel_act_q |-> miso_oen_q) // [RULE3]
    else $error("data output driven during released frame");

  a_release_one_frame: assert property (ce_i && cs_rise |=> // [RULE3]
    !rel_act_q && miso_oen_q)
    else $error("release outlived its frame");

  a_count_split_hi: assert property (s_load_hi |=> // [RULE19]
    resp_q[RESP_DATA_LSB +: REG_W] ==
    {{(2*REG_W-CNT_W){1'b0}}, $past(cap_cnt_q[CNT_W-1:REG_W])})
    else $error("high count register wrong");

  a_count_split_lo: assert property (ce_i && resp_load_q && hit_lo |=> // [RULE9]
    resp_q[RESP_DATA_LSB +: REG_W] == $past(cap_cnt_q[REG_W-1:0]))
    else $error("low count register wrong");

  a_resp_marker: assert property (ce_i && resp_load_q |=> // [RULE1]
    resp_q[FRAME_BITS-1] && resp_q[CRC_W-1:0] == $past(crc_w) &&
    resp_q[RESP_DATA_LSB +: REG_W] == $past(rdata))
    else $error("response word not loaded with marker and check");

  a_release_arm: assert property (ce_i && wr_sync && cmd_data[SYNC_RELEASE_BIT] // [RULE3]
    |=> rel_pend_q)
    else $error("release bit not armed by write");

  a_release_start: assert property (s_release_start |=> // [RULE3]
    rel_act_q && miso_oen_q && !rel_pend_q)
    else $error("released frame did not start floating");

  a_drive_start: assert property (s_drive_start |=> !miso_oen_q) // [RULE3]
    else $error("data output not driven in selected frame");

  a_rate_load: assert property (ce_i && wr_filter |=> // [RULE6]
    rate_q == $past(cmd_data[RATE_W-1:0]))
    else $error("rate code not loaded");

  a_flags_write: assert property (ce_i && wr_sync |=> // [RULE7]
    align_q == $past(cmd_data[SYNC_ALIGN_BIT]) &&
    capture_q == $past(cmd_data[SYNC_CAPTURE_BIT]))
    else $error("align or capture bit not written");

  a_capture_hold: assert property (ce_i && !take |=> cap_cnt_q == $past(cap_cnt_q)) // [RULE7]
    else $error("captured count changed without a select fall");

  a_ready_pulse: assert property (ce_i && sample_ready_o && !restart |=> // [RULE5]
    !sample_ready_o)
    else $error("sample ready wider than one cycle");

  a_settle_end: assert property (s_settle_last |=> !settling_q) // [RULE15]
    else $error("settling flag outlived third period");

endmodule

// ===== dv/msc_host_model.sv
// host side serial main model for the sync counter block
module msc_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF_NS = 80;

  time fall_t;
  logic [31:0] rx_word;
  event done;

  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    fall_t = 0;
    rx_word = '0;
  end

  //==========================================================================
  // full 32-bit frame: mosi set on falling edge, miso taken on rising edge
  task automatic frame(input logic [31:0] cmd);
    cs_n_o = 1'b0;
    fall_t = $time;
    for (int i = 31; i >= 0; i--) begin
      #HALF_NS sclk_o = 1'b0;
      mosi_o = cmd[i];
      #HALF_NS sclk_o = 1'b1;
      rx_word[i] = miso_i;
    end
    #HALF_NS cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    ->done;
    #200;
  endtask

  //==========================================================================
  // select toggle with no serial clock
  task automatic null_frame();
    cs_n_o = 1'b0;
    fall_t = $time;
    #200 cs_n_o = 1'b1;
    #200;
  endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench for the sync counter block
module testbench
  import msc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic [1:0] kind;
    logic [31:0] word;
    int cnt;
  } msc_exp_s;

  logic ref_clk, resetn, ce, miso, miso_oen, sample_ready, settling, float_pat, drove;
  wire logic sclk, cs_n, mosi, miso_line;
  int err_total, tests_run, n, cnt_exp;
  time t0, t1, settle_until;
  logic [7:0] hi_byte;
  logic [2:0] code;
  msc_exp_s exp_q[$];
  msc_exp_s e;

  // released line shows a toggling pattern, not the last value
  assign miso_line = (miso_oen === 1'b0) ? miso : float_pat;

  msc_sync_top dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .ce_i(ce), .sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oen_o(miso_oen),
    .sample_ready_o(sample_ready), .settling_o(settling));
  msc_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_line));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) float_pat <= ~float_pat;
  always @(negedge cs_n) drove = 1'b0;
  always @(posedge ref_clk) if (!cs_n && miso_oen === 1'b0) drove = 1'b1;

  //==========================================================================
  // helpers
  function automatic logic [15:0] ccitt(input logic [15:0] d);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction

  function automatic int reload(input logic [2:0] r);
    case (r)
      3'h0: return 32'h01FF;
      3'h3: return 32'h07FF;
      3'h5: return 32'h0FFF;
      3'h6: return 32'h1FFF;
      3'h7: return 32'h3FFF;
      3'h1: return int'(RELOAD_C1_DEF);
      3'h2: return int'(RELOAD_C2_DEF);
      default: return int'(RELOAD_C4_DEF);
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input logic [13:0] got, input logic [13:0] exp);
    tests_run++;
    if ($isunknown(got) || (got > exp + 14'h0001) || (exp > got + 14'h0001)) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_pulse(output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end while (sample_ready !== 1'b1 && cyc < 20000);
    if (sample_ready !== 1'b1) err_total++;
  endtask

  // one command frame; notes the response expected in the following frame
  task automatic xfer(input logic rw, input logic [7:0] addr, input logic [7:0] wd,
                      input logic [7:0] exp_d, input logic [1:0] kind, input int cnt);
    logic [15:0] hdr;
    msc_exp_s nx;
    host.frame({rw, 7'h00, addr, wd, 8'($urandom)});
    hdr = {1'b1, ($time < settle_until), ~rw, 5'h00, exp_d};
    nx.kind = kind;
    nx.word = {hdr, ccitt(hdr)};
    nx.cnt = cnt;
    exp_q.push_back(nx);
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  //==========================================================================
  // response watcher
  always @(host.done) begin
    if (exp_q.size() == 0) begin
      chk(32'h0, 32'h1);
    end else begin
      e = exp_q.pop_front();
      if (e.kind == 2'h0) begin
        chk(host.rx_word, e.word);
      end else if (e.kind == 2'h1) begin
        chk({31'h0, drove}, 32'h0);
      end else begin
        chk({8'h00, host.rx_word[31:24], host.rx_word[15:0]},
            {8'h00, e.word[31:24], ccitt(host.rx_word[31:16])});
        if (e.kind == 2'h2) begin
          hi_byte = host.rx_word[23:16];
          chk({30'h0, hi_byte[7:6]}, 32'h0);
        end else begin
          chk_near({hi_byte[5:0], host.rx_word[23:16]}, 14'(e.cnt));
        end
      end
    end
  end

  //==========================================================================
  // main sequence
  initial begin
    err_total = 0;
    tests_run = 0;
    settle_until = 0;
    float_pat = 1'b0;
    drove = 1'b0;
    hi_byte = '0;
    resetn = 1'b0;
    ce = 1'b1;
    void'($urandom(32'hD80A));
    exp_q.push_back('{2'h0, {16'h8000, ccitt(16'h8000)}, 0});
    repeat (4) @(negedge ref_clk);
    chk({30'h0, miso_oen, sample_ready}, 32'h2);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    #3;
    for (int i = 0; i < 8; i++) begin
      code = 3'(i + 4);
      xfer(1'b0, ADDR_FILTER_CFG, {5'h00, code}, {5'h00, code}, 2'h0, 0);
      wait_pulse(n);
      wait_pulse(n);
      chk(32'(n), 32'(reload(code) + 1));
    end
    // clock enable low freezes the period counter, frozen cycles go uncounted
    @(negedge ref_clk) ce = 1'b0;
    repeat (100) @(negedge ref_clk);
    ce = 1'b1;
    wait_pulse(n);
    chk(32'(n), 32'(reload(code) + 1));
    xfer(1'b0, ADDR_SYNC_CTRL, 8'h04, 8'h04, 2'h1, 0);
    xfer(1'b1, ADDR_SYNC_CTRL, 8'h00, 8'h00, 2'h0, 0);
    xfer(1'b1, 8'h20, 8'h00, 8'h00, 2'h0, 0);
    xfer(1'b0, ADDR_SYNC_CTRL, 8'h01, 8'h01, 2'h0, 0);
    settle_until = $time + 64'd40960;
    xfer(1'b0, ADDR_SYNC_CTRL, 8'h02, 8'h02, 2'h0, 0);
    t0 = host.fall_t;
    chk({31'h0, settling}, 32'h1);
    host.null_frame();
    t1 = host.fall_t;
    // the take edge latches the count of the cycle before it
    cnt_exp = 2047 - ((int'((t1 - t0) / 10) - 1) % 2048);
    xfer(1'b1, ADDR_CNT_HIGH, 8'h00, 8'h00, 2'h2, 0);
    xfer(1'b1, ADDR_CNT_LOW, 8'h00, 8'h00, 2'h3, cnt_exp);
    xfer(1'b1, ADDR_SYNC_CTRL, 8'h00, 8'h00, 2'h0, 0);
    repeat (3) wait_pulse(n);
    chk({31'h0, settling}, 32'h0);
    xfer(1'b1, ADDR_FILTER_CFG, 8'h00, 8'h03, 2'h0, 0);
    xfer(1'b1, 8'h20, 8'h00, 8'h00, 2'h0, 0);
    xfer(1'b1, ADDR_SYNC_CTRL, 8'h00, 8'h00, 2'h0, 0);
    chk(32'(exp_q.size()), 32'h1);
    results();
  end

  // about twice the longest expected run
  initial begin
    #2_000_000;
    err_total++;
    results();
  end
endmodule
